// ===== core/lrdc_regs.svh
// Constants for the lane receiver detect control block
`ifndef LRDC_REGS_SVH
`define LRDC_REGS_SVH
`define LRDC_CLK_HZ         200000000
`define LRDC_POLL_MS        12
`define LRDC_WINDOW_MS      600
`define LRDC_POLL_CYCLES    ((`LRDC_CLK_HZ / 1000) * `LRDC_POLL_MS)
`define LRDC_WINDOW_POLLS   (`LRDC_WINDOW_MS / `LRDC_POLL_MS)
`define LRDC_PD_MIN_US      5
`define LRDC_PD_MIN_CYCLES  ((`LRDC_CLK_HZ / 1000000) * `LRDC_PD_MIN_US)
`endif

// ===== core/lrdc_pkg.sv
// Types for the lane receiver detect control block
package lrdc_pkg;
    typedef enum logic [4:0] {
        LRDC_POWERDOWN  = 5'h01,
        LRDC_AUTO_SCAN  = 5'h02,
        LRDC_AUTO_STOP  = 5'h04,
        LRDC_MANUAL_OFF = 5'h08,
        LRDC_MANUAL_ON  = 5'h10
    } lrdc_mode_type;
endpackage : lrdc_pkg

// ===== core/lrdc_lane.sv
// One lane: latches its own detection result and drives termination and output enable
`timescale 1ns/1ps
`default_nettype none
module lrdc_lane (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic restart,
    input  wire logic probe,
    input  wire logic sense_p,
    input  wire logic sense_n,
    input  wire logic auto_mode,
    input  wire logic manual_on,
    input  wire logic power_down,
    output logic      detected,
    output logic      term_enable,
    output logic      output_active
);
    logic next_detected;
    wire  both_loaded = sense_p & sense_n;

    // Both halves must see a valid load, else stays high impedance
    assign next_detected = restart ? 1'b0 : (detected | (probe & both_loaded));

    // Power down overrides, manual follows pin, auto follows result
    function automatic logic lane_on(
        input logic pd,
        input logic auto_sel,
        input logic found,
        input logic pin_on
    );
        return !pd && (auto_sel ? found : pin_on);
    endfunction : lane_on

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            detected      <= 1'b0;
            term_enable   <= 1'b0;
            output_active <= 1'b0;
        end else begin
            detected      <= next_detected;
            term_enable   <= lane_on(power_down, auto_mode, next_detected, manual_on);
            output_active <= lane_on(power_down, auto_mode, next_detected, manual_on);
        end
    end

    property p_probe_needs_both;
        @(posedge clk) disable iff (!nrst)
        (probe && !restart && !(sense_p && sense_n) && !detected) |=> !detected;
    endproperty
    a_probe_needs_both: assert property (p_probe_needs_both)
        else $error("detection without both halves loaded");
    property p_term_off_in_pd;
        @(posedge clk) disable iff (!nrst)
        power_down |=> !term_enable && !output_active;
    endproperty
    a_term_off_in_pd: assert property (p_term_off_in_pd)
        else $error("termination on during power down");
endmodule : lrdc_lane
`default_nettype wire

// ===== core/lrdc_top.sv
// Receiver detect and termination control for all lanes
`timescale 1ns/1ps
`default_nettype none
`include "lrdc_regs.svh"
// How it works
// - Presence and manual select both low gives automatic detection; manual select high hands termination to the control pin.
// - Automatic mode with control pin low probes every 12 ms until every lane has found a receiver.
// - Automatic mode with control pin high probes at the same rate only for a 600 ms window, then stops.
// - In automatic mode termination stays high impedance until detection, then goes to 50 ohm.
// - A rising edge on the control pin in windowed mode restarts the window.
// - Manual mode with control pin low disables detection, keeps termination off and outputs idle.
// - Manual mode with control pin high disables detection, turns termination on and outputs active.
// - A falling edge on presence resets detection and starts a new sequence.
// - A receiver counts only when both halves of the pair see a valid load.
// - Each lane is enabled from its own detection result.
module lrdc_top #(
    parameter int LANES       = 4,
    parameter int POLL_CYCLES = `LRDC_POLL_CYCLES,
    parameter int WIN_POLLS   = `LRDC_WINDOW_POLLS
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             card_present_n,
    input  wire logic             manual_termination_select,
    input  wire logic             termination_detect_control,
    input  wire logic [LANES-1:0] far_receiver_sensing_p,
    input  wire logic [LANES-1:0] far_receiver_sensing_n,
    output logic      [LANES-1:0] lane_detected,
    output logic      [LANES-1:0] input_termination_50,
    output logic      [LANES-1:0] output_active,
    output logic                  power_saving,
    output logic                  probe_strobe,
    output logic                  window_expired
);
    // ****************************************
    // Pin history and mode decode
    // ****************************************
    logic present_q;
    logic ctrl_q;
    logic [31:0] poll_cnt;
    logic [15:0] win_cnt;
    logic [15:0] win_probes;
    lrdc_pkg::lrdc_mode_type mode;

    wire power_down   = card_present_n;
    wire auto_mode    = !card_present_n && !manual_termination_select;
    wire manual_on    = termination_detect_control;
    wire reinit       = present_q && !card_present_n;
    wire ctrl_rise    = !ctrl_q && termination_detect_control;
    wire win_restart  = auto_mode && termination_detect_control && ctrl_rise;
    wire restart      = reinit || !auto_mode;
    wire cnt_clear    = restart || win_restart;
    wire all_found    = &lane_detected;
    wire win_done     = termination_detect_control && (win_cnt >= 16'(WIN_POLLS));
    wire poll_tick    = (poll_cnt == 32'(POLL_CYCLES - 1));
    wire probe_fire   = auto_mode && !cnt_clear && poll_tick && !win_done && !all_found;

    assign mode = power_down ? lrdc_pkg::LRDC_POWERDOWN :
                  !auto_mode ? (manual_on ? lrdc_pkg::LRDC_MANUAL_ON
                                          : lrdc_pkg::LRDC_MANUAL_OFF) :
                  win_done   ? lrdc_pkg::LRDC_AUTO_STOP : lrdc_pkg::LRDC_AUTO_SCAN;
    assign power_saving   = (mode == lrdc_pkg::LRDC_POWERDOWN);
    assign window_expired = (mode == lrdc_pkg::LRDC_AUTO_STOP);

    // ****************************************
    // Timebase counters
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // High, so a low pin at release counts as a fall
            present_q    <= 1'b1;
            ctrl_q       <= 1'b0;
            poll_cnt     <= 32'h0;
            win_cnt      <= 16'h0;
            probe_strobe <= 1'b0;
        end else begin
            present_q    <= card_present_n;
            ctrl_q       <= termination_detect_control;
            probe_strobe <= probe_fire;
            if (cnt_clear) begin
                poll_cnt <= 32'h0;
                win_cnt  <= 16'h0;
            end else if (poll_tick) begin
                poll_cnt <= 32'h0;
                // With control pin high, saturates at the window end until a restart; with it low, keeps counting
                if (!win_done)
                    win_cnt <= win_cnt + 16'h1;
            end else begin
                poll_cnt <= poll_cnt + 32'h1;
            end
        end
    end

    // ****************************************
    // Per-lane detection, each lane on its own
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            lrdc_lane u_lane (
                .clk           (clk),
                .nrst          (nrst),
                .restart       (restart),
                .probe         (probe_fire),
                .sense_p       (far_receiver_sensing_p[gi]),
                .sense_n       (far_receiver_sensing_n[gi]),
                .auto_mode     (auto_mode),
                .manual_on     (manual_on),
                .power_down    (power_down),
                .detected      (lane_detected[gi]),
                .term_enable   (input_termination_50[gi]),
                .output_active (output_active[gi])
            );
        end
    endgenerate

    // ****************************************
    // Window probe budget, checker side only
    // ****************************************
    // Counted apart from win_cnt, so a miscount there shows up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            win_probes <= 16'h0;
        end else if (cnt_clear) begin
            win_probes <= 16'h0;
        end else if (probe_fire && termination_detect_control) begin
            win_probes <= win_probes + 16'h1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_no_probe_manual;
        @(posedge clk) disable iff (!nrst) !auto_mode |=> !probe_strobe && lane_detected == '0;
    endproperty
    a_no_probe_manual: assert property (p_no_probe_manual)
        else $error("probe outside automatic mode");
    property p_manual_on;
        @(posedge clk) disable iff (!nrst)
        (!card_present_n && manual_termination_select && termination_detect_control)
        |=> &input_termination_50;
    endproperty
    a_manual_on: assert property (p_manual_on)
        else $error("manual on did not enable termination");
    property p_manual_off;
        @(posedge clk) disable iff (!nrst)
        (!card_present_n && manual_termination_select && !termination_detect_control)
        |=> !(|output_active);
    endproperty
    a_manual_off: assert property (p_manual_off)
        else $error("manual off left outputs active");
    property p_window_stops;
        @(posedge clk) disable iff (!nrst) window_expired |-> !probe_fire;
    endproperty
    a_window_stops: assert property (p_window_stops)
        else $error("probe after window expired");
    property p_reinit_clears;
        @(posedge clk) disable iff (!nrst) reinit |=> lane_detected == '0 && poll_cnt == 32'h0;
    endproperty
    a_reinit_clears: assert property (p_reinit_clears)
        else $error("presence fall did not reset detection");
    property p_probe_spacing;
        @(posedge clk) disable iff (!nrst) probe_fire |=> !probe_fire [*8];
    endproperty
    a_probe_spacing: assert property (p_probe_spacing)
        else $error("probes too close together");
    property p_restart_window;
        @(posedge clk) disable iff (!nrst) win_restart |=> win_cnt == 16'h0;
    endproperty
    a_restart_window: assert property (p_restart_window)
        else $error("window not restarted");
    property p_pd_outputs;
        @(posedge clk) disable iff (!nrst)
        card_present_n |-> power_saving ##1 (output_active == '0 && input_termination_50 == '0);
    endproperty
    a_pd_outputs: assert property (p_pd_outputs)
        else $error("power down not applied");
    property p_window_budget;
        @(posedge clk) disable iff (!nrst) win_probes <= 16'(WIN_POLLS);
    endproperty
    a_window_budget: assert property (p_window_budget)
        else $error("too many probes in one window");
    property p_counters_clear;
        @(posedge clk) disable iff (!nrst)
        cnt_clear |=> poll_cnt == 32'h0 && win_cnt == 16'h0 && win_probes == 16'h0;
    endproperty
    a_counters_clear: assert property (p_counters_clear)
        else $error("counters not cleared");
    // Per-lane view: termination follows only that lane's own result
    for (gi = 0; gi < LANES; gi++) begin : g_lane_chk
        property p_lane_waits;
            @(posedge clk) disable iff (!nrst)
            (auto_mode && !lane_detected[gi] && !probe_fire) |=> !input_termination_50[gi];
        endproperty
        a_lane_waits: assert property (p_lane_waits)
            else $error("termination on before detection");
        property p_lane_found;
            @(posedge clk) disable iff (!nrst)
            (probe_fire && far_receiver_sensing_p[gi] && far_receiver_sensing_n[gi])
            |=> lane_detected[gi] && input_termination_50[gi];
        endproperty
        a_lane_found: assert property (p_lane_found)
            else $error("loaded lane not enabled after probe");
        property p_lane_unloaded;
            @(posedge clk) disable iff (!nrst)
            (auto_mode && !lane_detected[gi] && !far_receiver_sensing_p[gi])
            |=> !lane_detected[gi];
        endproperty
        a_lane_unloaded: assert property (p_lane_unloaded)
            else $error("half-loaded lane reported as found");
    end
    c_manual:   cover property (@(posedge clk) disable iff (!nrst) mode == lrdc_pkg::LRDC_MANUAL_ON);
    c_probe:    cover property (@(posedge clk) disable iff (!nrst) probe_fire);
    c_found:    cover property (@(posedge clk) disable iff (!nrst) |lane_detected);
    c_expired:  cover property (@(posedge clk) disable iff (!nrst) window_expired);
    c_restart:  cover property (@(posedge clk) disable iff (!nrst) win_restart);
endmodule : lrdc_top
`default_nettype wire

// ===== verif/lrdc_far_load.sv
// Far-end receiver load model for the lane receiver detect control bench
`timescale 1ns/1ps
`default_nettype none
module lrdc_far_load #(
    parameter int LANES = 4
) (
    input  wire logic [LANES-1:0] load_p,
    input  wire logic [LANES-1:0] load_n,
    output logic      [LANES-1:0] sense_p,
    output logic      [LANES-1:0] sense_n
);
    // Halves report alone, so a pair with one unloaded half is never whole
    assign sense_p = load_p;
    assign sense_n = load_n;
endmodule : lrdc_far_load
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the lane receiver detect control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic       pres_n;
        logic       man;
        logic       ctl;
        logic [3:0] lp;
        logic [3:0] ln;
        logic [3:0] term;
        logic       ps;
    } lrdc_row_type;
    logic         clk, nrst, pres_n, man, ctl, ps, strobe, expired;
    logic   [3:0] lp, ln, sp, sn, det, term, act;
    int           n_fail, cmp_count, i, k;
    lrdc_row_type rows [6];
    lrdc_far_load #(.LANES(4)) i_load (.load_p(lp), .load_n(ln), .sense_p(sp), .sense_n(sn));
    lrdc_top #(.LANES(4), .POLL_CYCLES(16), .WIN_POLLS(3)) i_dut (
        .clk(clk), .nrst(nrst), .card_present_n(pres_n), .manual_termination_select(man),
        .termination_detect_control(ctl), .far_receiver_sensing_p(sp),
        .far_receiver_sensing_n(sn), .lane_detected(det), .input_termination_50(term),
        .output_active(act), .power_saving(ps), .probe_strobe(strobe),
        .window_expired(expired));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    // Bounded, a missing strobe ends the run instead of hanging it
    task automatic wait_strobe;
        k = 0;
        while (strobe !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 100) begin
            n_fail++;
            summarize();
        end
    endtask : wait_strobe
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        nrst      = 1'b0;
        pres_n    = 1'b1;
        man       = 1'b0;
        ctl       = 1'b0;
        lp        = 4'h0;
        ln        = 4'h0;
        n_fail    = 0;
        cmp_count = 0;
        rows[0] = '{1'b1, 1'b0, 1'b0, 4'hf, 4'hf, 4'h0, 1'b1};
        rows[1] = '{1'b0, 1'b1, 1'b0, 4'hf, 4'hf, 4'h0, 1'b0};
        rows[2] = '{1'b0, 1'b1, 1'b1, 4'h0, 4'h0, 4'hf, 1'b0};
        rows[3] = '{1'b0, 1'b0, 1'b1, 4'h3, 4'h3, 4'h3, 1'b0};
        rows[4] = '{1'b1, 1'b0, 1'b0, 4'hf, 4'hf, 4'h0, 1'b1};
        rows[5] = '{1'b0, 1'b0, 1'b0, 4'h7, 4'hd, 4'h5, 1'b0};
        cycles(1);
        check(term, 4'h0);
        @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            pres_n <= rows[i].pres_n;
            man    <= rows[i].man;
            ctl    <= rows[i].ctl;
            lp     <= rows[i].lp;
            ln     <= rows[i].ln;
            cycles(1000);
            check(term, rows[i].term);
            check(act, rows[i].term);
            check(ps, rows[i].ps);
        end
        // Poll spacing while lanes are still missing
        wait_strobe();
        @(posedge clk);
        #1;
        wait_strobe();
        check(k + 1, 16);
        // Detection is sticky until presence is cycled
        @(posedge clk);
        lp <= 4'ha;
        ln <= 4'ha;
        cycles(40);
        check(term, 4'hf);
        @(posedge clk);
        pres_n <= 1'b1;
        cycles(1000);
        @(posedge clk);
        pres_n <= 1'b0;
        cycles(40);
        check(det, 4'ha);
        check(term, 4'ha);
        // Windowed mode runs out, then a rising edge restarts it
        @(posedge clk);
        pres_n <= 1'b1;
        lp     <= 4'h0;
        ln     <= 4'h0;
        ctl    <= 1'b1;
        cycles(1000);
        @(posedge clk);
        pres_n <= 1'b0;
        cycles(80);
        check(expired, 1'b1);
        @(posedge clk);
        lp <= 4'hf;
        ln <= 4'hf;
        cycles(40);
        check(term, 4'h0);
        @(posedge clk);
        ctl <= 1'b0;
        @(posedge clk);
        ctl <= 1'b1;
        cycles(40);
        check(expired, 1'b0);
        check(term, 4'hf);
        // Reset in mid-run, released with presence already low
        @(posedge clk);
        nrst <= 1'b0;
        cycles(2);
        check(det, 4'h0);
        @(posedge clk);
        nrst <= 1'b1;
        cycles(2);
        check(term, 4'h0);
        cycles(40);
        check(term, 4'hf);
        summarize();
    end
endmodule : testbench
`default_nettype wire
